/* hdl/hgc_top.sv */
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "hgc_defs.svh"

module hgc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // audio samples
    input wire logic sample_stb_i,
    input wire logic [15:0] left_sample_i,
    input wire logic [15:0] right_sample_i,
    // amplifier controls
    output logic phones_left_enable_o,
    output logic phones_right_enable_o,
    output logic phones_left_tristate_o,
    output logic phones_right_tristate_o,
    output logic mixer_right_invert_o,
    output logic master_startup_enable_o,
    output logic [1:0] pump_level_o,
    // realised gains
    output logic [5:0] phones_left_gain_o,
    output logic [5:0] phones_right_gain_o,
    output logic [5:0] line_out_left_gain_o,
    output logic [5:0] line_out_right_gain_o,
    output logic [3:0] input_amp_left_gain_o,
    output logic [3:0] input_amp_right_gain_o,
    output logic [5:0] aux_left_gain_o,
    output logic [5:0] aux_right_gain_o,
    output logic [7:0] dac_left_gain_o,
    output logic [7:0] dac_right_gain_o
);
    // saturating subtract, floor at zero
    function automatic logic [7:0] hgc_sat_sub(
        input logic [7:0] a,
        input logic [7:0] b);
        hgc_sat_sub = (a > b) ? a - b : 8'h00;
    endfunction

    // codes under the lowest step read as mute
    function automatic logic [5:0] hgc_eff(input logic [5:0] c);
        hgc_eff = (c < `HGC_CODE_MIN) ? `HGC_CODE_MUTE : c;
    endfunction

    // sample magnitude, most negative kept exact as 16'h8000
    function automatic logic [15:0] hgc_abs(input logic [15:0] x);
        hgc_abs = x[15] ? 16'h0000 - x : x;
    endfunction

    // software registers
    logic [7:0] ctrl;
    logic [7:0] mst;
    logic [7:0] aux_l;
    logic [7:0] aux_r;
    logic [7:0] inpga;
    logic [7:0] dac_l;
    logic [7:0] dac_r;
    logic [7:0] mixr;
    logic [7:0] lo_l;
    logic [7:0] lo_r;
    logic [7:0] hp_l;
    logic [7:0] hp_r;
    logic [7:0] cfg;
    logic [7:0] zx;

    // bus decode
    wire [5:0] idx = adr_i[7:2];
    wire req = cyc_i && stb_i;
    wire wr = req && we_i && ack_o && sel_i[0];
    wire [7:0] stat;
    wire [7:0] rd_byte =
        (idx == `HGC_IDX_CTRL) ? ctrl :
        (idx == `HGC_IDX_MST) ? mst :
        (idx == `HGC_IDX_AUXL) ? aux_l :
        (idx == `HGC_IDX_AUXR) ? aux_r :
        (idx == `HGC_IDX_INPGA) ? inpga :
        (idx == `HGC_IDX_DACL) ? dac_l :
        (idx == `HGC_IDX_DACR) ? dac_r :
        (idx == `HGC_IDX_MIXR) ? mixr :
        (idx == `HGC_IDX_LOL) ? lo_l :
        (idx == `HGC_IDX_LOR) ? lo_r :
        (idx == `HGC_IDX_HPL) ? hp_l :
        (idx == `HGC_IDX_HPR) ? hp_r :
        (idx == `HGC_IDX_HPCFG) ? cfg :
        (idx == `HGC_IDX_ZX) ? zx :
        (idx == `HGC_IDX_STAT) ? stat : 8'h00;

    // one wait state; unmapped reads answer zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req && !ack_o;
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // write takes effect on the edge that sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `HGC_RST_REG;
            mst <= `HGC_RST_REG;
            aux_l <= `HGC_RST_REG;
            aux_r <= `HGC_RST_REG;
            inpga <= `HGC_RST_REG;
            dac_l <= `HGC_RST_REG;
            dac_r <= `HGC_RST_REG;
            mixr <= `HGC_RST_REG;
            lo_l <= `HGC_RST_VOL;
            lo_r <= `HGC_RST_VOL;
            hp_l <= `HGC_RST_VOL;
            hp_r <= `HGC_RST_VOL;
            cfg <= `HGC_RST_REG;
            zx <= `HGC_RST_REG;
        end else if (wr) begin
            unique case (idx)
                `HGC_IDX_CTRL: ctrl <= dat_i[7:0];
                `HGC_IDX_MST: mst <= dat_i[7:0];
                `HGC_IDX_AUXL: aux_l <= dat_i[7:0];
                `HGC_IDX_AUXR: aux_r <= dat_i[7:0];
                `HGC_IDX_INPGA: inpga <= dat_i[7:0];
                `HGC_IDX_DACL: dac_l <= dat_i[7:0];
                `HGC_IDX_DACR: dac_r <= dat_i[7:0];
                `HGC_IDX_MIXR: mixr <= dat_i[7:0];
                `HGC_IDX_LOL: lo_l <= dat_i[7:0];
                `HGC_IDX_LOR: lo_r <= dat_i[7:0];
                `HGC_IDX_HPL: hp_l <= dat_i[7:0];
                `HGC_IDX_HPR: hp_r <= dat_i[7:0];
                `HGC_IDX_HPCFG: cfg <= dat_i[7:0];
                `HGC_IDX_ZX: zx <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // gain targets; tracking copies the right code
    wire track = cfg[`HGC_CFG_TRACK];
    wire [5:0] tgt_l = track ? hp_r[5:0] : hp_l[5:0];
    wire [5:0] tgt_r = hp_r[5:0];
    wire [5:0] app_l;
    wire [5:0] app_r;
    wire pend_l;
    wire pend_r;

    // one zero-cross tracker per channel
    hgc_zc_chan u_zc_left (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_stb_i(sample_stb_i),
        .sample_sign_i(left_sample_i[15]),
        .zc_enable_i(zx[`HGC_ZX_L]),
        .target_i(tgt_l),
        .applied_o(app_l),
        .pending_o(pend_l)
    );

    hgc_zc_chan u_zc_right (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_stb_i(sample_stb_i),
        .sample_sign_i(right_sample_i[15]),
        .zc_enable_i(zx[`HGC_ZX_R]),
        .target_i(tgt_r),
        .applied_o(app_r),
        .pending_o(pend_r)
    );

    // noise mode split of the applied code
    wire nsup = ctrl[`HGC_CTRL_NSUP];
    wire dac2hp = ctrl[`HGC_CTRL_DAC2HP];
    wire hi_l = app_l > `HGC_CODE_0DB;
    wire hi_r = app_r > `HGC_CODE_0DB;
    wire [7:0] boost_l = hi_l ? {2'b00, app_l - `HGC_CODE_0DB} : 8'h00;
    wire [7:0] boost_r = hi_r ? {2'b00, app_r - `HGC_CODE_0DB} : 8'h00;
    wire [7:0] cut_l = hi_l ? 8'h00 : {2'b00, `HGC_CODE_0DB - app_l};
    wire [7:0] cut_r = hi_r ? 8'h00 : {2'b00, `HGC_CODE_0DB - app_r};
    // 1.5 dB per phones step, four DAC steps each
    wire [7:0] dcut_l = {cut_l[5:0], 2'b00};
    wire [7:0] dcut_r = {cut_r[5:0], 2'b00};

    // phones stage holds 0 dB while lower stages cut
    wire mid_l = !hi_l && (app_l >= `HGC_CODE_MIN);
    wire mid_r = !hi_r && (app_r >= `HGC_CODE_MIN);
    wire [5:0] next_ph_l = (nsup && mid_l) ? `HGC_CODE_0DB : hgc_eff(app_l);
    wire [5:0] next_ph_r = (nsup && mid_r) ? `HGC_CODE_0DB : hgc_eff(app_r);

    // boost taken back at the input amplifier
    wire [7:0] in_l8 = hgc_sat_sub({4'h0, inpga[3:0]}, boost_l);
    wire [7:0] in_r8 = hgc_sat_sub({4'h0, inpga[7:4]}, boost_r);
    wire [3:0] next_in_l = nsup ? in_l8[3:0] : inpga[3:0];
    wire [3:0] next_in_r = nsup ? in_r8[3:0] : inpga[7:4];

    // ambient path cut moves to the aux amplifier
    wire [7:0] ax_l8 = hgc_sat_sub({2'b00, aux_l[5:0]}, cut_l);
    wire [7:0] ax_r8 = hgc_sat_sub({2'b00, aux_r[5:0]}, cut_r);
    wire [5:0] next_aux_l = nsup ? ax_l8[5:0] : aux_l[5:0];
    wire [5:0] next_aux_r = nsup ? ax_r8[5:0] : aux_r[5:0];

    // playback cut moves to the DAC digital gain
    wire dcut_on = nsup && dac2hp;
    wire [7:0] next_dac_l = dcut_on ? hgc_sat_sub(dac_l, dcut_l) : dac_l;
    wire [7:0] next_dac_r = dcut_on ? hgc_sat_sub(dac_r, dcut_r) : dac_r;

    // pump level from averaged magnitude
    wire [16:0] mag_sum = {1'b0, hgc_abs(left_sample_i)}
        + {1'b0, hgc_abs(right_sample_i)};
    wire [15:0] avg = mag_sum[16:1];
    wire restr = cfg[`HGC_CFG_RESTR];
    wire [1:0] lvl_full =
        (avg < `HGC_TH_QUARTER) ? hgc_pkg::HGC_PUMP_QUARTER :
        (avg < `HGC_TH_THIRD) ? hgc_pkg::HGC_PUMP_THIRD :
        (avg < `HGC_TH_HALF) ? hgc_pkg::HGC_PUMP_HALF :
        hgc_pkg::HGC_PUMP_FULL;
    // restricted pump lacks the second flying cap
    wire [1:0] lvl_two = (avg < `HGC_TH_HALF) ?
        hgc_pkg::HGC_PUMP_HALF : hgc_pkg::HGC_PUMP_FULL;
    wire [1:0] next_pump = restr ? lvl_two : lvl_full;

    assign stat = {4'h0, pend_r, pend_l, pump_level_o};

    // pump steps only on the sample strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pump_level_o <= hgc_pkg::HGC_PUMP_FULL;
        end else if (sample_stb_i) begin
            pump_level_o <= next_pump;
        end
    end

    // plain controls, registered to the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phones_left_enable_o <= 1'b0;
            phones_right_enable_o <= 1'b0;
            phones_left_tristate_o <= 1'b0;
            phones_right_tristate_o <= 1'b0;
            mixer_right_invert_o <= 1'b0;
            master_startup_enable_o <= 1'b0;
        end else begin
            phones_left_enable_o <= cfg[`HGC_CFG_LEN];
            phones_right_enable_o <= cfg[`HGC_CFG_REN];
            phones_left_tristate_o <= cfg[`HGC_CFG_LHZ];
            phones_right_tristate_o <= cfg[`HGC_CFG_RHZ];
            mixer_right_invert_o <= mixr[`HGC_MIX_RINV];
            master_startup_enable_o <= mst[`HGC_MST_EN];
        end
    end

    // realised gains, all stages move on the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phones_left_gain_o <= `HGC_CODE_MUTE;
            phones_right_gain_o <= `HGC_CODE_MUTE;
            line_out_left_gain_o <= `HGC_CODE_MUTE;
            line_out_right_gain_o <= `HGC_CODE_MUTE;
            input_amp_left_gain_o <= 4'h0;
            input_amp_right_gain_o <= 4'h0;
            aux_left_gain_o <= 6'h00;
            aux_right_gain_o <= 6'h00;
            dac_left_gain_o <= 8'h00;
            dac_right_gain_o <= 8'h00;
        end else begin
            phones_left_gain_o <= next_ph_l;
            phones_right_gain_o <= next_ph_r;
            line_out_left_gain_o <= hgc_eff(lo_l[5:0]);
            line_out_right_gain_o <= hgc_eff(lo_r[5:0]);
            input_amp_left_gain_o <= next_in_l;
            input_amp_right_gain_o <= next_in_r;
            aux_left_gain_o <= next_aux_l;
            aux_right_gain_o <= next_aux_r;
            dac_left_gain_o <= next_dac_l;
            dac_right_gain_o <= next_dac_r;
        end
    end

    // bus answers
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !ack_o) |=> ack_o)
        else $error("request not answered next cycle");

    AST_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && idx == `HGC_IDX_HPCFG)
        |=> ##1 phones_left_tristate_o == $past(dat_i[`HGC_CFG_LHZ], 2))
        else $error("tristate pin does not follow config write");
    AST_MUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        (app_l < `HGC_CODE_MIN) |=> phones_left_gain_o == `HGC_CODE_MUTE)
        else $error("low code did not mute left phones");
    AST_TRACK: assert property (@(posedge clk_i) disable iff (rst_i)
        (track && zx[1:0] == 2'b00)[*3] |-> app_l == app_r)
        else $error("tracking left gain differs from right");
    AST_RESTR: assert property (@(posedge clk_i) disable iff (rst_i)
        (restr && sample_stb_i) |=> !pump_level_o[1])
        else $error("restricted pump chose third or quarter");
    AST_NOSUP: assert property (@(posedge clk_i) disable iff (rst_i)
        !nsup |=> input_amp_left_gain_o == $past(inpga[3:0])
            && aux_left_gain_o == $past(aux_l[5:0]))
        else $error("gains moved outside noise mode");
    AST_BOOST: assert property (@(posedge clk_i) disable iff (rst_i)
        (nsup && hi_l && inpga[3:0] == 4'hf && app_l == 6'h38)
        |=> input_amp_left_gain_o == 4'hc && phones_left_gain_o == 6'h38)
        else $error("boost not taken back at input amp");
    AST_DACCUT: assert property (@(posedge clk_i) disable iff (rst_i)
        (dcut_on && app_l == 6'h30 && dac_l == 8'hff)
        |=> dac_left_gain_o == 8'heb && phones_left_gain_o == `HGC_CODE_0DB)
        else $error("DAC cut for -7.5 dB is wrong");

    COV_NSUP_BOOST: cover property (@(posedge clk_i) disable iff (rst_i)
        nsup && hi_l);
    COV_NSUP_CUT: cover property (@(posedge clk_i) disable iff (rst_i)
        dcut_on && mid_r);
    COV_PUMP_QTR: cover property (@(posedge clk_i) disable iff (rst_i)
        pump_level_o == hgc_pkg::HGC_PUMP_QUARTER);
endmodule // hgc_top

`default_nettype wire

/* include/hgc_defs.svh */
`ifndef HGC_DEFS_SVH
`define HGC_DEFS_SVH

// register indices, byte address is four times the index
`define HGC_IDX_CTRL 6'h01
`define HGC_IDX_MST 6'h03
`define HGC_IDX_AUXL 6'h09
`define HGC_IDX_AUXR 6'h0a
`define HGC_IDX_INPGA 6'h0c
`define HGC_IDX_DACL 6'h15
`define HGC_IDX_DACR 6'h16
`define HGC_IDX_MIXR 6'h1d
`define HGC_IDX_LOL 6'h1e
`define HGC_IDX_LOR 6'h1f
`define HGC_IDX_HPL 6'h21
`define HGC_IDX_HPR 6'h22
`define HGC_IDX_HPCFG 6'h23
`define HGC_IDX_ZX 6'h24
`define HGC_IDX_STAT 6'h25

// field positions
`define HGC_CTRL_NSUP 0
`define HGC_CTRL_DAC2HP 1
`define HGC_MST_EN 0
`define HGC_MIX_RINV 0
`define HGC_CFG_LEN 0
`define HGC_CFG_REN 1
`define HGC_CFG_LHZ 2
`define HGC_CFG_RHZ 3
`define HGC_CFG_TRACK 4
`define HGC_CFG_RESTR 5
`define HGC_ZX_L 0
`define HGC_ZX_R 1

// reset values
`define HGC_RST_REG 8'h00
`define HGC_RST_VOL 8'h10

// volume code points
`define HGC_CODE_MUTE 6'h10
`define HGC_CODE_MIN 6'h11
`define HGC_CODE_0DB 6'h35

// zero-cross timeout in sample periods
`define HGC_ZC_TIMEOUT 12'd2048

// pump thresholds on the average magnitude
`define HGC_TH_QUARTER 16'h2000
`define HGC_TH_THIRD 16'h2aaa
`define HGC_TH_HALF 16'h4000

`endif

/* include/hgc_pkg.sv */
package hgc_pkg;
    typedef enum logic [1:0] {
        HGC_PUMP_FULL = 2'b00,
        HGC_PUMP_HALF = 2'b01,
        HGC_PUMP_THIRD = 2'b10,
        HGC_PUMP_QUARTER = 2'b11
    } hgc_pump_e;

    typedef enum logic {
        HGC_ZC_IDLE = 1'b0,
        HGC_ZC_WAIT = 1'b1
    } hgc_zc_e;
endpackage

/* hdl/hgc_zc_chan.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hgc_defs.svh"

module hgc_zc_chan (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // audio side
    input wire logic sample_stb_i,
    input wire logic sample_sign_i,
    // gain request
    input wire logic zc_enable_i,
    input wire logic [5:0] target_i,
    // applied gain
    output logic [5:0] applied_o,
    output logic pending_o
);
    hgc_pkg::hgc_zc_e state;
    logic [11:0] cnt;
    logic [5:0] last_target;
    logic prev_sign;

    // crossing is a sign change between two strobed samples
    wire crossing = sample_stb_i && (sample_sign_i != prev_sign);
    wire timeout = sample_stb_i && (cnt == `HGC_ZC_TIMEOUT - 12'd1);
    wire retarget = target_i != last_target;
    wire differs = target_i != applied_o;
    wire take = !zc_enable_i || crossing || timeout;

    assign pending_o = state == hgc_pkg::HGC_ZC_WAIT;

    // input history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_target <= `HGC_CODE_MUTE;
            prev_sign <= 1'b0;
        end else begin
            last_target <= target_i;
            if (sample_stb_i) begin
                prev_sign <= sample_sign_i;
            end
        end
    end

    // pending update and timeout, one copy per channel
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= hgc_pkg::HGC_ZC_IDLE;
            cnt <= 12'd0;
            applied_o <= `HGC_CODE_MUTE;
        end else begin
            unique case (state)
                hgc_pkg::HGC_ZC_IDLE: begin
                    cnt <= 12'd0;
                    if (differs && !zc_enable_i) begin
                        applied_o <= target_i;
                    end else if (differs) begin
                        state <= hgc_pkg::HGC_ZC_WAIT;
                    end
                end
                hgc_pkg::HGC_ZC_WAIT: begin
                    if (take) begin
                        applied_o <= target_i;
                        state <= hgc_pkg::HGC_ZC_IDLE;
                        cnt <= 12'd0;
                    end else if (retarget) begin
                        cnt <= 12'd0;
                    end else if (sample_stb_i) begin
                        cnt <= cnt + 12'd1;
                    end
                end
            endcase
        end
    end

    AST_ZC_DIRECT: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == hgc_pkg::HGC_ZC_IDLE && differs && !zc_enable_i)
        |=> applied_o == $past(target_i))
        else $error("gain not applied at once with zero-cross off");
    AST_ZC_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
        (pending_o && timeout) |=> !pending_o && applied_o == $past(target_i))
        else $error("zero-cross timeout did not apply the pending gain");
    COV_ZC_TIMEOUT: cover property (@(posedge clk_i) disable iff (rst_i)
        pending_o && timeout && !crossing);
    COV_ZC_CROSS: cover property (@(posedge clk_i) disable iff (rst_i)
        pending_o && crossing);
endmodule // hgc_zc_chan

`default_nettype wire

/* verification/hgc_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hgc_defs.svh"

module hgc_top_bench;
    // clock, reset and bus drive
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic sample_stb_i = 1'b0;
    logic [15:0] left_sample_i = 16'h1000;
    logic [15:0] right_sample_i = 16'h1000;
    wire logic [31:0] dat_o;
    wire logic ack_o;
    wire logic len_o, ren_o, ltri_o, rtri_o, rinv_o, mst_o;
    wire logic [1:0] pump_o;
    wire logic [5:0] hpl_o, hpr_o, lol_o, lor_o, auxl_o, auxr_o;
    wire logic [3:0] inl_o, inr_o;
    wire logic [7:0] dacl_o, dacr_o;
    int errors = 0;
    int cmp_count = 0;

    always #5 clk_i = ~clk_i;

    hgc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sample_stb_i(sample_stb_i), .left_sample_i(left_sample_i),
        .right_sample_i(right_sample_i), .phones_left_enable_o(len_o),
        .phones_right_enable_o(ren_o), .phones_left_tristate_o(ltri_o),
        .phones_right_tristate_o(rtri_o), .mixer_right_invert_o(rinv_o),
        .master_startup_enable_o(mst_o), .pump_level_o(pump_o),
        .phones_left_gain_o(hpl_o), .phones_right_gain_o(hpr_o),
        .line_out_left_gain_o(lol_o), .line_out_right_gain_o(lor_o),
        .input_amp_left_gain_o(inl_o), .input_amp_right_gain_o(inr_o),
        .aux_left_gain_o(auxl_o), .aux_right_gain_o(auxr_o),
        .dac_left_gain_o(dacl_o), .dac_right_gain_o(dacr_o));

    // single verdict point, also reached by a stuck bus
    task automatic give_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [5:0] idx, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, idx, 8'h00, q);
        chk(q, {24'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // strobe pulses one cycle wide, one idle cycle between
    task automatic strobe(input int n);
        repeat (n) begin
            @(posedge clk_i);
            sample_stb_i <= 1'b1;
            @(posedge clk_i);
            sample_stb_i <= 1'b0;
        end
        cyc(3);
    endtask

    // pump level for a pair of samples against the expected code
    task automatic pump(input logic [15:0] l, input logic [15:0] r, input logic [1:0] exp);
        left_sample_i <= l;
        right_sample_i <= r;
        strobe(1);
        chk({30'h0, pump_o}, {30'h0, exp});
    endtask

    initial begin
        cyc(5);
        rst_i <= 1'b0;
        chk({26'h0, hpl_o}, 32'h10);
        rd_chk(`HGC_IDX_HPR, 8'h10);
        rd_chk(`HGC_IDX_HPCFG, 8'h00);
        rd_chk(6'h3f, 8'h00);
        // enables, tristates, inversion, master enable
        wr(`HGC_IDX_HPCFG, 8'h0f);
        wr(`HGC_IDX_MIXR, 8'h01);
        // pins only; nothing here leans on settled analogue outputs
        wr(`HGC_IDX_MST, 8'h01);
        cyc(3);
        chk({26'h0, len_o, ren_o, ltri_o, rtri_o, rinv_o, mst_o}, 32'h3f);
        wr(`HGC_IDX_HPCFG, 8'h05);
        cyc(3);
        chk({28'h0, len_o, ren_o, ltri_o, rtri_o}, 32'ha);
        rd_chk(`HGC_IDX_HPCFG, 8'h05);
        // volume codes, top code, lowest step and a low code that mutes
        wr(`HGC_IDX_HPL, 8'hff);
        wr(`HGC_IDX_HPR, 8'h11);
        wr(`HGC_IDX_LOL, 8'h05);
        wr(`HGC_IDX_LOR, 8'h3f);
        cyc(4);
        chk({8'h0, hpl_o, hpr_o, lol_o, lor_o}, {8'h0, 6'h3f, 6'h11, 6'h10, 6'h3f});
        rd_chk(`HGC_IDX_HPL, 8'hff);
        // tracking: right code drives both
        wr(`HGC_IDX_HPCFG, 8'h10);
        wr(`HGC_IDX_HPR, 8'h30);
        cyc(4);
        chk({20'h0, hpl_o, hpr_o}, {20'h0, 6'h30, 6'h30});
        wr(`HGC_IDX_HPCFG, 8'h00);
        cyc(4);
        chk({26'h0, hpl_o}, 32'h3f);
        // pump levels from averaged magnitude, then restricted mode
        pump(16'h1000, 16'h1000, 2'b11);
        pump(16'hf000, 16'h1000, 2'b11);
        pump(16'h2800, 16'h2800, 2'b10);
        pump(16'h3000, 16'h3000, 2'b01);
        pump(16'h5000, 16'h5000, 2'b00);
        wr(`HGC_IDX_HPCFG, 8'h20);
        pump(16'h1000, 16'h1000, 2'b01);
        pump(16'h2800, 16'h2800, 2'b01);
        pump(16'h5000, 16'h3000, 2'b00);
        // left waits for its crossing, right applies at once
        pump(16'h1000, 16'h1000, 2'b01);
        wr(`HGC_IDX_ZX, 8'h01);
        wr(`HGC_IDX_HPL, 8'h2a);
        wr(`HGC_IDX_HPR, 8'h25);
        strobe(3);
        chk({20'h0, hpl_o, hpr_o}, {20'h0, 6'h3f, 6'h25});
        rd_chk(`HGC_IDX_STAT, 8'h05);
        left_sample_i <= 16'hf000;
        strobe(1);
        chk({26'h0, hpl_o}, 32'h2a);
        // right timeout, restarted by a second write
        wr(`HGC_IDX_ZX, 8'h02);
        wr(`HGC_IDX_HPR, 8'h30);
        strobe(1000);
        wr(`HGC_IDX_HPR, 8'h31);
        strobe(2047);
        chk({26'h0, hpr_o}, 32'h25);
        strobe(1);
        chk({26'h0, hpr_o}, 32'h31);
        // gain redistribution only while noise mode is on; presets come first
        wr(`HGC_IDX_ZX, 8'h00);
        wr(`HGC_IDX_INPGA, 8'hff);
        wr(`HGC_IDX_AUXL, 8'h3f);
        wr(`HGC_IDX_AUXR, 8'h3f);
        wr(`HGC_IDX_DACL, 8'hff);
        wr(`HGC_IDX_DACR, 8'h80);
        wr(`HGC_IDX_HPL, 8'h38);
        cyc(4);
        chk({28'h0, inl_o}, 32'hf);
        chk({14'h0, inr_o, auxr_o, dacr_o}, {14'h0, 4'hf, 6'h3f, 8'h80});
        // level control and DAC ramping live outside this block and stay off
        wr(`HGC_IDX_CTRL, 8'h03);
        cyc(4);
        chk({16'h0, hpl_o, hpr_o, inl_o}, {16'h0, 6'h38, 6'h35, 4'hc});
        chk({14'h0, inr_o, auxr_o, dacr_o}, {14'h0, 4'hf, 6'h3b, 8'h70});
        // only the phones volume is written while noise mode is on
        wr(`HGC_IDX_HPL, 8'h30);
        cyc(4);
        chk({12'h0, hpl_o, auxl_o, dacl_o}, {12'h0, 6'h35, 6'h3a, 8'heb});
        // playback not routed to the phones: DAC gain stays, aux still cuts
        wr(`HGC_IDX_CTRL, 8'h01);
        cyc(4);
        chk({18'h0, auxl_o, dacl_o}, {18'h0, 6'h3a, 8'hff});
        give_verdict();
    end
endmodule // hgc_top_bench

`default_nettype wire
